// File: hdl/cdsl_consts.svh
// Constants shared by the clock driver switch latch ends
`ifndef CDSL_CONSTS_SVH
`define CDSL_CONSTS_SVH

// Channel and bank geometry
`define CDSL_CHANNELS 24
`define CDSL_BANK_BITS 12
`define CDSL_BUS_BITS 16
`define CDSL_SW_ADDR_BITS 3
`define CDSL_BOARD_BITS 4

// Switch-state bus fields
`define CDSL_SW_ADDR_MSB 15
`define CDSL_SW_ADDR_LSB 13
`define CDSL_BANK_SEL_POS 12

// Serial word fields, most significant bit sent first
`define CDSL_WORD_BITS 24
`define CDSL_WBOARD_MSB 23
`define CDSL_WBOARD_LSB 20
`define CDSL_WPKG_MSB 19
`define CDSL_WPKG_LSB 16
`define CDSL_WD3_POS 19
`define CDSL_WD2_POS 18
`define CDSL_WA0_POS 15
`define CDSL_WA1_POS 14
`define CDSL_WM1_POS 13
`define CDSL_WM0_POS 12
`define CDSL_WVAL_MSB 11
`define CDSL_DAC_PACKAGES 12
`define CDSL_MON_A_LSB 0
`define CDSL_MON_B_LSB 6
`define CDSL_MON_IDX_BITS 5

// Controller register byte offsets
`define CDSL_REG_CTRL 5'h00
`define CDSL_REG_SWITCH 5'h04
`define CDSL_REG_SERIAL 5'h08
`define CDSL_REG_MONSEL 5'h0c
`define CDSL_REG_STATUS 5'h10
`define CDSL_CTRL_ENABLE_POS 0
`define CDSL_CTRL_DUAL_POS 1
`define CDSL_DELAY_LSB 16
`define CDSL_DELAY_BITS 8

// Serial bit period in mclk cycles (about 3.3 Mbit/s at 10 MHz)
`define CDSL_SER_DIV 3

`endif

// File: hdl/cdsl_pkg.sv
// Types shared by the clock driver switch latch ends
package cdsl_pkg;
    // Controller serial shifter states, one-hot
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b01,
        SER_SHIFT = 2'b10
    } cdsl_ser_state_t;

    // Decoded kind of a received serial word
    typedef enum logic [2:0] {
        WORD_NONE = 3'b001,
        WORD_DAC  = 3'b010,
        WORD_MUX  = 3'b100
    } cdsl_word_kind_t;
endpackage

// File: hdl/cdsl_link_if.sv
// Backplane link between the timing controller and one driver board
interface cdsl_link_if;
    logic [15:0] switchBus;
    logic switchWriteStrobe;
    logic dualBankUpdateLine;
    logic clockOutputEnable;
    logic serialData;
    logic serialBitValid;
    logic serialFrame;

    modport board (
        input switchBus,
        input switchWriteStrobe,
        input dualBankUpdateLine,
        input clockOutputEnable,
        input serialData,
        input serialBitValid,
        input serialFrame
    );

    modport ctrl (
        output switchBus,
        output switchWriteStrobe,
        output dualBankUpdateLine,
        output clockOutputEnable,
        output serialData,
        output serialBitValid,
        output serialFrame
    );
endinterface

// File: hdl/cdsl_board.sv
// Driver board end: switch latches, output disconnect, serial word decoder
//
// The address map and register access over Avalon-MM were decided locally.

`include "cdsl_consts.svh"

module cdsl_board #(
    parameter int CHANNELS = `CDSL_CHANNELS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Backplane link
    cdsl_link_if.board link,
    // Jumper settings, an installed jumper reads 0
    input wire logic [2:0] switchAddressJumpers,
    input wire logic [3:0] boardAddressJumpers,
    // Per-channel analog switch controls
    output logic [23:0] railSelect,
    output logic [23:0] driverConnect,
    // Rail DAC load request
    output logic dacLoad,
    output logic [3:0] dacPackage,
    output logic [1:0] dacChannel,
    output logic [11:0] dacValue,
    // Diagnostic selector
    output logic [4:0] monitorSelectA,
    output logic [4:0] monitorSelectB
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Bank split and selector width are fixed by the bus and word formats
    if (CHANNELS != 2 * `CDSL_BANK_BITS) begin : gen_bad_channels
        $error("cdsl_board: CHANNELS must equal two banks of twelve");
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch-state capture

    logic strobeSeen;
    logic strobeRise;
    logic addressMatch;
    logic [11:0] captureData;

    // Previous strobe level; the bus is sampled synchronously to mclk
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strobeSeen <= 1'b0;
        end else begin
            strobeSeen <= link.switchWriteStrobe;
        end
    end

    // Only the asserting edge counts, so a long strobe loads once
    assign strobeRise = link.switchWriteStrobe & ~strobeSeen;

    // Top three bus bits address the board, bit 12 is never data
    assign addressMatch = (link.switchBus[`CDSL_SW_ADDR_MSB:`CDSL_SW_ADDR_LSB]
                           == switchAddressJumpers);
    assign captureData = link.switchBus[`CDSL_BANK_BITS-1:0];

    // Lower bank latch; held until the next qualifying write to it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            railSelect[11:0] <= 12'h000;
        end else if (strobeRise && addressMatch) begin
            if (link.dualBankUpdateLine
                || !link.switchBus[`CDSL_BANK_SEL_POS]) begin
                railSelect[11:0] <= captureData;
            end
        end
    end

    // Upper bank latch; dual mode copies the same twelve bits here too
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            railSelect[23:12] <= 12'h000;
        end else if (strobeRise && addressMatch) begin
            if (link.dualBankUpdateLine
                || link.switchBus[`CDSL_BANK_SEL_POS]) begin
                railSelect[23:12] <= captureData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output disconnect switches

    // One switch per channel after its amplifier; a bit of 1 in
    // railSelect routes the upper rail, 0 the lower rail, and the
    // disconnect overrides whichever rail is chosen
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gen_channel
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    driverConnect[ch] <= 1'b0;
                end else begin
                    driverConnect[ch] <= link.clockOutputEnable;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Serial word receiver

    logic [4:0] bitCount;
    logic [22:0] shiftReg;
    logic wordDone;
    logic [23:0] fullWord;

    // Last bit of a word completes it; earlier bits are held in shiftReg
    assign wordDone = link.serialFrame && link.serialBitValid
                      && (bitCount == 5'(`CDSL_WORD_BITS - 1));
    assign fullWord = {shiftReg, link.serialData};

    // Bit counter restarts whenever the frame drops, so a broken word
    // is discarded rather than merged with the next one
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bitCount <= 5'h00;
        end else if (!link.serialFrame || wordDone) begin
            bitCount <= 5'h00;
        end else if (link.serialBitValid) begin
            bitCount <= bitCount + 5'h01;
        end
    end

    // Most significant bit arrives first and shifts toward the top
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shiftReg <= 23'h000000;
        end else if (link.serialFrame && link.serialBitValid) begin
            shiftReg <= {shiftReg[21:0], link.serialData};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial word decode

    cdsl_pkg::cdsl_word_kind_t wordKind;
    logic boardMatch;
    logic modeDac;
    logic modeSel;
    logic [3:0] wordPackage;
    logic [4:0] wordMonA;
    logic [4:0] wordMonB;

    // Jumper levels compare directly: installed means a zero bit
    assign boardMatch = (fullWord[`CDSL_WBOARD_MSB:`CDSL_WBOARD_LSB]
                         == boardAddressJumpers);
    assign modeDac = !fullWord[`CDSL_WM1_POS] && !fullWord[`CDSL_WM0_POS];
    assign modeSel = fullWord[`CDSL_WM1_POS] && fullWord[`CDSL_WM0_POS];
    assign wordPackage = fullWord[`CDSL_WPKG_MSB:`CDSL_WPKG_LSB];
    assign wordMonA = fullWord[`CDSL_MON_A_LSB +: `CDSL_MON_IDX_BITS];
    assign wordMonB = fullWord[`CDSL_MON_B_LSB +: `CDSL_MON_IDX_BITS];

    // Classify a finished word; packages 12-15 and gain words belong
    // to other board types and are ignored here
    always_comb begin
        wordKind = cdsl_pkg::WORD_NONE;
        if (wordDone && boardMatch) begin
            if (modeDac && wordPackage < 4'(`CDSL_DAC_PACKAGES)) begin
                wordKind = cdsl_pkg::WORD_DAC;
            end else if (modeSel && !fullWord[`CDSL_WD3_POS]
                         && !fullWord[`CDSL_WD2_POS]) begin
                wordKind = cdsl_pkg::WORD_MUX;
            end
        end
    end

    // DAC load request: one-cycle pulse with the word's fields.
    // Each of 12 packages holds four DACs, giving 48 rail voltages.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dacLoad <= 1'b0;
            dacPackage <= 4'h0;
            dacChannel <= 2'h0;
            dacValue <= 12'h000;
        end else begin
            dacLoad <= 1'b0;
            case (wordKind)
                cdsl_pkg::WORD_DAC: begin
                    dacLoad <= 1'b1;
                    dacPackage <= wordPackage;
                    dacChannel <= {fullWord[`CDSL_WA1_POS], fullWord[`CDSL_WA0_POS]};
                    dacValue <= fullWord[`CDSL_WVAL_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Monitor selector; an index beyond the last channel is refused and
    // that connector keeps its previous choice
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            monitorSelectA <= 5'h00;
            monitorSelectB <= 5'h00;
        end else begin
            case (wordKind)
                cdsl_pkg::WORD_MUX: begin
                    if (wordMonA < 5'(CHANNELS)) begin
                        monitorSelectA <= wordMonA;
                    end
                    if (wordMonB < 5'(CHANNELS)) begin
                        monitorSelectB <= wordMonB;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limitations

    // Only three switch address bits exist, so boards sharing a switch
    // jumper setting latch identical timing on every write.

endmodule

// File: hdl/cdsl_ctrl.sv
// Timing controller end: Avalon-MM registers driving the backplane link
`include "cdsl_consts.svh"

module cdsl_ctrl #(
    parameter int SER_DIV = `CDSL_SER_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // System conditions
    input wire logic powerGood,
    input wire logic dspResetActive,
    // Delay counter load
    output logic [7:0] delayCount,
    // Backplane link
    cdsl_link_if.ctrl link
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // The bit-rate divider counter is only eight bits wide
    if (SER_DIV < 1 || SER_DIV > 255) begin : gen_bad_div
        $error("cdsl_ctrl: SER_DIV must lie in 1..255");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    cdsl_pkg::cdsl_ser_state_t serState;
    logic readAck;
    logic serialHit;
    logic wrCtrl;
    logic wrSwitch;
    logic wrSend;
    logic [23:0] sendWord;
    logic enableReq;

    // Serial writes stall while a word is still shifting
    assign serialHit = (address == `CDSL_REG_SERIAL) || (address == `CDSL_REG_MONSEL);
    assign waitrequest = (read && !readAck)
                         || (write && serialHit && serState != cdsl_pkg::SER_IDLE);
    assign wrCtrl = write && !waitrequest && address == `CDSL_REG_CTRL;
    assign wrSwitch = write && !waitrequest && address == `CDSL_REG_SWITCH;
    assign wrSend = write && !waitrequest && serialHit;

    // Monitor command: board, then first and second channel index
    always_comb begin
        sendWord = writedata[23:0];
        if (address == `CDSL_REG_MONSEL) begin
            sendWord = {writedata[3:0], 4'h0, 2'h0, 2'h3,
                        1'b0, writedata[13:9], 1'b0, writedata[8:4]};
        end
    end

    // Reads take one wait cycle so that readdata comes from a register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            readAck <= 1'b0;
            readdata <= 32'h00000000;
        end else begin
            readAck <= read && !readAck;
            if (read && !readAck) begin
                case (address)
                    `CDSL_REG_CTRL: readdata <= {30'h0, link.dualBankUpdateLine, enableReq};
                    `CDSL_REG_SWITCH: readdata <= {8'h00, delayCount, link.switchBus};
                    `CDSL_REG_STATUS: readdata <= {29'h0, powerGood, link.clockOutputEnable,
                                                   serState != cdsl_pkg::SER_IDLE};
                    default: readdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control latch

    // Bit 1 is the hardware latch behind the dual-bank line
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enableReq <= 1'b0;
            link.dualBankUpdateLine <= 1'b0;
        end else if (wrCtrl) begin
            enableReq <= writedata[`CDSL_CTRL_ENABLE_POS];
            link.dualBankUpdateLine <= writedata[`CDSL_CTRL_DUAL_POS];
        end
    end

    // Enable is forced false without good power or during a DSP reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link.clockOutputEnable <= 1'b0;
        end else begin
            link.clockOutputEnable <= enableReq && powerGood && !dspResetActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch-state write

    // Bus and strobe rise together and the bus holds afterwards
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link.switchBus <= 16'h0000;
            link.switchWriteStrobe <= 1'b0;
            delayCount <= 8'h00;
        end else begin
            link.switchWriteStrobe <= wrSwitch;
            if (wrSwitch) begin
                link.switchBus <= writedata[`CDSL_BUS_BITS-1:0];
                delayCount <= writedata[`CDSL_DELAY_LSB +: `CDSL_DELAY_BITS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial shifter

    logic [7:0] divCount;
    logic [4:0] bitsLeft;
    logic [23:0] shiftReg;
    logic bitTick;

    assign bitTick = (divCount == 8'(SER_DIV - 1));

    // Bit-rate divider, restarted with each word
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divCount <= 8'h00;
        end else if (serState == cdsl_pkg::SER_IDLE || bitTick) begin
            divCount <= 8'h00;
        end else begin
            divCount <= divCount + 8'h01;
        end
    end

    // Most significant bit first, one bit per divider tick
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serState <= cdsl_pkg::SER_IDLE;
            bitsLeft <= 5'h00;
            shiftReg <= 24'h000000;
            link.serialData <= 1'b0;
            link.serialBitValid <= 1'b0;
            link.serialFrame <= 1'b0;
        end else begin
            link.serialBitValid <= 1'b0;
            case (serState)
                cdsl_pkg::SER_IDLE: begin
                    if (wrSend) begin
                        shiftReg <= sendWord;
                        bitsLeft <= 5'(`CDSL_WORD_BITS);
                        link.serialFrame <= 1'b1;
                        serState <= cdsl_pkg::SER_SHIFT;
                    end
                end
                cdsl_pkg::SER_SHIFT: begin
                    if (bitsLeft == 5'h00) begin
                        link.serialFrame <= 1'b0;
                        serState <= cdsl_pkg::SER_IDLE;
                    end else if (bitTick) begin
                        link.serialData <= shiftReg[23];
                        link.serialBitValid <= 1'b1;
                        shiftReg <= {shiftReg[22:0], 1'b0};
                        bitsLeft <= bitsLeft - 5'h01;
                    end
                end
                default: begin
                    serState <= cdsl_pkg::SER_IDLE;
                end
            endcase
        end
    end

endmodule

// File: test/cdsl_link_assertions.sv
// Assertions on the backplane link and the board outputs
module cdsl_link_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Backplane link
    input wire logic [15:0] switchBus,
    input wire logic switchWriteStrobe,
    input wire logic dualBankUpdateLine,
    input wire logic clockOutputEnable,
    input wire logic serialBitValid,
    input wire logic serialFrame,
    // Controller conditions and board jumpers
    input wire logic powerGood,
    input wire logic dspResetActive,
    input wire logic [2:0] switchAddressJumpers,
    // Board outputs
    input wire logic [23:0] railSelect,
    input wire logic [23:0] driverConnect,
    input wire logic [4:0] monitorSelectA,
    input wire logic [4:0] monitorSelectB
);
    timeunit 1ns;
    timeprecision 1ns;

    logic addrHit;

    // Address match; a capture also needs a rising strobe
    assign addrHit = switchBus[15:13] == switchAddressJumpers;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Switch latch
    strobe_single_pulse_a: assert property (switchWriteStrobe |=> !switchWriteStrobe)
        else $error("switch strobe longer than one cycle");
    lower_bank_load_a: assert property ($rose(switchWriteStrobe) && addrHit
        && (!switchBus[12] || dualBankUpdateLine) |=> railSelect[11:0] == $past(switchBus[11:0]))
        else $error("lower bank not loaded");
    upper_bank_load_a: assert property ($rose(switchWriteStrobe) && addrHit
        && (switchBus[12] || dualBankUpdateLine) |=> railSelect[23:12] == $past(switchBus[11:0]))
        else $error("upper bank not loaded");
    lower_bank_keep_a: assert property ($rose(switchWriteStrobe) && addrHit
        && switchBus[12] && !dualBankUpdateLine |=> $stable(railSelect[11:0]))
        else $error("lower bank changed by upper write");
    rail_bits_hold_a: assert property (!($rose(switchWriteStrobe) && addrHit)
        |=> $stable(railSelect))
        else $error("rail bits changed without a capture");

    ////////////////////////////////////////////////////////////////////////////////////////
    // Output enable
    output_disconnect_a: assert property (driverConnect == {24{$past(clockOutputEnable)}})
        else $error("driver outputs do not follow the enable");
    unsafe_enable_off_a: assert property (($past(dspResetActive) || !$past(powerGood))
        |-> !clockOutputEnable)
        else $error("enable true while unsafe");

    ////////////////////////////////////////////////////////////////////////////////////////
    // Serial word and monitor selector
    bit_in_frame_a: assert property (serialBitValid |-> serialFrame)
        else $error("serial bit outside a frame");
    monitor_range_a: assert property (monitorSelectA <= 5'h17 && monitorSelectB <= 5'h17)
        else $error("monitor index above last channel");
endmodule

// File: test/clock_driver_switch_latch_test.sv
// Self-checking bench driving both ends of the switch latch link
`include "cdsl_consts.svh"

`define CDSL_CHECK(name, exp, got) \
    begin \
        samplesChecked++; \
        if ((got) !== (exp)) begin \
            failCount++; \
            $display("unexpected %s expected %h seen %h", name, (exp), (got)); \
        end \
    end

module clock_driver_switch_latch_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;
    logic rstn;
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic powerGood;
    logic dspResetActive;
    logic [7:0] delayCount;
    logic [2:0] swJumpers;
    logic [3:0] brdJumpers;
    logic [23:0] railSelect;
    logic [23:0] driverConnect;
    logic dacLoad;
    logic [3:0] dacPackage;
    logic [1:0] dacChannel;
    logic [11:0] dacValue;
    logic [4:0] monitorSelectA;
    logic [4:0] monitorSelectB;
    logic wrqSnap;
    logic [31:0] rdSnap;
    logic [31:0] rd;
    int dacLoads = 0;
    int failCount;
    int samplesChecked;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Both ends joined by one link
    cdsl_link_if link();
    cdsl_ctrl cdsl_ctrl_i (.mclk(mclk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .powerGood(powerGood), .dspResetActive(dspResetActive), .delayCount(delayCount),
        .link(link));
    cdsl_board cdsl_board_i (.mclk(mclk), .rstn(rstn), .link(link),
        .switchAddressJumpers(swJumpers), .boardAddressJumpers(brdJumpers),
        .railSelect(railSelect), .driverConnect(driverConnect), .dacLoad(dacLoad),
        .dacPackage(dacPackage), .dacChannel(dacChannel), .dacValue(dacValue),
        .monitorSelectA(monitorSelectA), .monitorSelectB(monitorSelectB));
    cdsl_link_assertions cdsl_link_assertions_i (.mclk(mclk), .rstn(rstn),
        .switchBus(link.switchBus), .switchWriteStrobe(link.switchWriteStrobe),
        .dualBankUpdateLine(link.dualBankUpdateLine),
        .clockOutputEnable(link.clockOutputEnable), .serialBitValid(link.serialBitValid),
        .serialFrame(link.serialFrame), .powerGood(powerGood),
        .dspResetActive(dspResetActive), .switchAddressJumpers(swJumpers),
        .railSelect(railSelect), .driverConnect(driverConnect),
        .monitorSelectA(monitorSelectA), .monitorSelectB(monitorSelectB));

    // Clock, 100 ns period
    always #50 mclk = ~mclk;

    // Mid-cycle snapshot, settled value that the next rising edge takes
    always @(negedge mclk) begin
        wrqSnap = waitrequest;
        rdSnap = readdata;
    end

    // Count load pulses; each stands one cycle only
    always @(posedge mclk) begin
        if (dacLoad === 1'b1) dacLoads <= dacLoads + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus tasks; the request holds until waitrequest is seen low
    task automatic avWrite(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge mclk); while (wrqSnap !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic avRead(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        address <= a;
        read <= 1'b1;
        do @(posedge mclk); while (wrqSnap !== 1'b0);
        d = rdSnap;
        read <= 1'b0;
    endtask

    // Poll status until the shifter is idle, bounded
    task automatic waitIdle();
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 100 && s[0] !== 1'b0; i++) begin
            avRead(`CDSL_REG_STATUS, s);
        end
    endtask

    // Let link and board updates land, then look mid-cycle
    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask

    function automatic logic [31:0] monWord(input logic [3:0] b, input logic [4:0] x,
        input logic [4:0] y);
        return {18'h0, y, x, b};
    endfunction

    task automatic finalReport();
        if (failCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles of the tests
    initial begin
        repeat (20000) @(posedge mclk);
        failCount++;
        finalReport();
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        powerGood = 1'b1;
        dspResetActive = 1'b0;
        swJumpers = 3'h5;
        brdJumpers = 4'ha;
        failCount = 0;
        samplesChecked = 0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        `CDSL_CHECK("railSelect", 24'h0, railSelect)
        `CDSL_CHECK("driverConnect", 24'h0, driverConnect)
        // Enable and the unsafe conditions that drop it
        avWrite(`CDSL_REG_CTRL, 32'h1);
        settle();
        `CDSL_CHECK("driverConnect", 24'hffffff, driverConnect)
        @(posedge mclk) dspResetActive <= 1'b1;
        settle();
        `CDSL_CHECK("driverConnect", 24'h0, driverConnect)
        avRead(`CDSL_REG_STATUS, rd);
        `CDSL_CHECK("status", 2'h2, rd[2:1])
        @(posedge mclk) dspResetActive <= 1'b0;
        powerGood <= 1'b0;
        settle();
        `CDSL_CHECK("driverConnect", 24'h0, driverConnect)
        @(posedge mclk) powerGood <= 1'b1;
        // Switch writes: lower, upper, foreign address, dual
        avWrite(`CDSL_REG_SWITCH, {8'h0, 8'h3c, 3'h5, 1'h0, 12'ha5c});
        settle();
        `CDSL_CHECK("railSelect", 12'ha5c, railSelect[11:0])
        `CDSL_CHECK("delayCount", 8'h3c, delayCount)
        avWrite(`CDSL_REG_SWITCH, {8'h0, 8'h0, 3'h5, 1'h1, 12'h3c1});
        settle();
        `CDSL_CHECK("railSelect", 24'h3c1a5c, railSelect)
        avWrite(`CDSL_REG_SWITCH, {8'h0, 8'h11, 3'h4, 1'h0, 12'hfff});
        settle();
        `CDSL_CHECK("railSelect", 24'h3c1a5c, railSelect)
        avRead(`CDSL_REG_SWITCH, rd);
        `CDSL_CHECK("switch readback", 24'h118fff, rd[23:0])
        avWrite(`CDSL_REG_CTRL, 32'h3);
        settle();
        `CDSL_CHECK("dual line", 1'b1, link.dualBankUpdateLine)
        avWrite(`CDSL_REG_SWITCH, {8'h0, 8'h0, 3'h5, 1'h1, 12'h7e2});
        settle();
        `CDSL_CHECK("railSelect", 24'h7e27e2, railSelect)
        avWrite(`CDSL_REG_CTRL, 32'h1);
        // Monitor selector: accepted, foreign board, index out of range
        avWrite(`CDSL_REG_MONSEL, monWord(4'ha, 5'h05, 5'h17));
        waitIdle();
        settle();
        `CDSL_CHECK("monitorSelectA", 5'h05, monitorSelectA)
        `CDSL_CHECK("monitorSelectB", 5'h17, monitorSelectB)
        avWrite(`CDSL_REG_MONSEL, monWord(4'h3, 5'h01, 5'h02));
        waitIdle();
        settle();
        `CDSL_CHECK("monitorSelectA", 5'h05, monitorSelectA)
        avWrite(`CDSL_REG_MONSEL, monWord(4'ha, 5'h18, 5'h00));
        waitIdle();
        settle();
        `CDSL_CHECK("monitorSelectA", 5'h05, monitorSelectA)
        `CDSL_CHECK("monitorSelectB", 5'h00, monitorSelectB)
        // Rail value word; a package number above the last one follows the gain word
        avWrite(`CDSL_REG_SERIAL, {8'h0, 4'ha, 4'h7, 1'h1, 1'h0, 2'h0, 12'h9b4});
        waitIdle();
        settle();
        `CDSL_CHECK("dac loads", 1, dacLoads)
        `CDSL_CHECK("dacPackage", 4'h7, dacPackage)
        `CDSL_CHECK("dacChannel", 2'h1, dacChannel)
        `CDSL_CHECK("dacValue", 12'h9b4, dacValue)
        // Gain word (mode 11, D3 D2 set) loads neither a rail nor the selector
        avWrite(`CDSL_REG_SERIAL, {8'h0, 4'ha, 4'hc, 2'h0, 2'h3, 12'h0c1});
        waitIdle();
        settle();
        `CDSL_CHECK("monitorSelectA", 5'h05, monitorSelectA)
        avWrite(`CDSL_REG_SERIAL, {8'h0, 4'ha, 4'hc, 4'h0, 12'h123});
        waitIdle();
        settle();
        `CDSL_CHECK("dac loads", 1, dacLoads)
        finalReport();
    end
endmodule
